// File: verilog/ccc_top.v
// Console configure controller: configure mode, input and dub settings, remote inputs, AHB-Lite registers
`timescale 1ns/1ns
`include "ccc_map.vh"
// Summary of operation
// - Enter configure after two-second configure hold
// - Configure mode mutes outputs, flashes orange
// - Configure remaps room-source, phones-source and dub buttons and indicators
// - Changes held locally, applied on exit
// - Room-source indicators show level; button toggles
// - Input 7 high indicator updates after exit
// - Phones-source held plus room-source toggles mono
// - Mono input routes left to both
// - Mono inputs flash in normal operation
// - Row one dub indicator shows dub level
// - Dub high indicator updates after exit
// - Remote 1 talk or source; 2 phones
// - Remote active while contact shorted to common
// - Remote inputs always momentary
// - Local talk buttons keep working
module ccc_top #(
    parameter CFG_HOLD_CYC = `CCC_CFG_HOLD_CYC,
    parameter DEB_CYC = `CCC_DEB_CYC,
    parameter FLASH_CYC = `CCC_FLASH_CYC
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire configure_btn_in,
    input wire [6:0] room_source_buttons_in,
    input wire phones_source_btn_in,
    input wire dub_btn_in,
    input wire talk_studio_btn_in,
    input wire talk_phones_btn_in,
    input wire remote_tip_n_in,
    input wire remote_ring_n_in,
    output reg configure_led_out,
    output reg [6:0] room_source_led_out,
    output reg [6:0] phones_source_led_out,
    output reg dub_row1_led_out,
    output reg input7_hilvl_led_out,
    output reg dub_hilvl_led_out,
    output reg audio_mute_out,
    output reg [6:0] input_hilvl_out,
    output reg [6:0] input_mono_out,
    output reg dub_hilvl_out,
    output reg talk_studio_out,
    output reg talk_phones_out,
    output reg remote_src_sel_out
);
    localparam ST_NORMAL = 2'b00;
    localparam ST_HOLD = 2'b01;
    localparam ST_CONFIG = 2'b10;
    localparam ST_RELEASE = 2'b11;

    // Contacts pull low when shorted, so invert before debounce
    wire [13:0] raw_w;
    wire [13:0] clean_w;
    wire [13:0] rise_w;
    assign raw_w = {~remote_ring_n_in, ~remote_tip_n_in, talk_phones_btn_in, talk_studio_btn_in, dub_btn_in,
                    phones_source_btn_in, configure_btn_in, room_source_buttons_in};

    ccc_debounce #(.WIDTH(14), .DEB_CYC(DEB_CYC)) u_deb (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .raw_in(raw_w),
        .clean_out(clean_w),
        .rise_out(rise_w)
    );

    wire [6:0] room_rise_w = rise_w[6:0];
    wire cfg_lvl_w = clean_w[7];
    wire cfg_rise_w = rise_w[7];
    wire phones_lvl_w = clean_w[8];
    wire dub_rise_w = rise_w[9];
    wire talk_s_rise_w = rise_w[10];
    wire talk_p_rise_w = rise_w[11];
    wire talk_s_lvl_w = clean_w[10];
    wire talk_p_lvl_w = clean_w[11];
    wire rem_tip_w = clean_w[12];
    wire rem_ring_w = clean_w[13];

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [24:0] hold_cnt_ff;
    reg [21:0] flash_cnt_ff;
    reg flash_ff;
    reg [6:0] pend_hilvl_ff;
    reg [6:0] pend_mono_ff;
    reg pend_dub_ff;
    reg [6:0] app_hilvl_ff;
    reg [6:0] app_mono_ff;
    reg app_dub_ff;
    reg [2:0] ctrl_ff;
    reg talk_s_latch_ff;
    reg talk_p_latch_ff;

    wire in_cfg_w = (state_ff == ST_CONFIG) || (state_ff == ST_RELEASE);

    // Debounced vector: rooms 0 to 6, configure 7, phones 8, dub 9, talk 10 and 11
    // Remote contacts sit at 12 and 13, apart from the local talk buttons
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_NORMAL: begin
                if (cfg_lvl_w) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!cfg_lvl_w) begin
                    nxt_state = ST_NORMAL;
                end else if (hold_cnt_ff >= CFG_HOLD_CYC - 1) begin
                    nxt_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Wait for the entering press to end so it is not taken as the exit press
                if (!cfg_lvl_w) begin
                    nxt_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (cfg_rise_w) begin
                    nxt_state = ST_NORMAL;
                end
            end
            default: begin
                nxt_state = ST_NORMAL;
            end
        endcase
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= ST_NORMAL;
            hold_cnt_ff <= 25'h0000000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_HOLD) begin
                hold_cnt_ff <= hold_cnt_ff + 25'h0000001;
            end else begin
                hold_cnt_ff <= 25'h0000000;
            end
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flash_cnt_ff <= 22'h000000;
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff >= FLASH_CYC - 1) begin
            flash_cnt_ff <= 22'h000000;
            flash_ff <= ~flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 22'h000001;
        end
    end

    // Pending settings are edited in configure mode only
    wire exit_w = (state_ff == ST_CONFIG) && (nxt_state == ST_NORMAL);
    wire enter_w = (state_ff == ST_HOLD) && (nxt_state == ST_RELEASE);
    integer i;
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pend_hilvl_ff <= 7'h00;
            pend_mono_ff <= 7'h00;
            pend_dub_ff <= 1'b0;
        end else if (enter_w) begin
            pend_hilvl_ff <= app_hilvl_ff;
            pend_mono_ff <= app_mono_ff;
            pend_dub_ff <= app_dub_ff;
        end else if (state_ff == ST_CONFIG) begin
            for (i = 0; i < `CCC_NUM_IN; i = i + 1) begin
                if (room_rise_w[i] && phones_lvl_w) begin
                    pend_mono_ff[i] <= ~pend_mono_ff[i];
                end else if (room_rise_w[i]) begin
                    pend_hilvl_ff[i] <= ~pend_hilvl_ff[i];
                end
            end
            if (dub_rise_w && !phones_lvl_w) begin
                pend_dub_ff <= ~pend_dub_ff;
            end
        end
    end

    // Applied settings only change on exit
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            app_hilvl_ff <= 7'h00;
            app_mono_ff <= 7'h00;
            app_dub_ff <= 1'b0;
        end else if (exit_w) begin
            app_hilvl_ff <= pend_hilvl_ff;
            app_mono_ff <= pend_mono_ff;
            app_dub_ff <= pend_dub_ff;
        end
    end

    // Local talk: latch or momentary per CTRL; remotes are always momentary
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            talk_s_latch_ff <= 1'b0;
            talk_p_latch_ff <= 1'b0;
        end else if (in_cfg_w) begin
            talk_s_latch_ff <= 1'b0;
            talk_p_latch_ff <= 1'b0;
        end else begin
            if (talk_s_rise_w) begin
                talk_s_latch_ff <= ~talk_s_latch_ff;
            end
            if (talk_p_rise_w) begin
                talk_p_latch_ff <= ~talk_p_latch_ff;
            end
        end
    end

    wire loc_s_w = ctrl_ff[`CCC_F_LATCH_STUDIO] ? talk_s_latch_ff : talk_s_lvl_w;
    wire loc_p_w = ctrl_ff[`CCC_F_LATCH_PHONES] ? talk_p_latch_ff : talk_p_lvl_w;
    wire rem_s_w = rem_tip_w & ~ctrl_ff[`CCC_F_REM1_SRC];
    wire rem_src_w = rem_tip_w & ctrl_ff[`CCC_F_REM1_SRC];

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            configure_led_out <= 1'b0;
            room_source_led_out <= 7'h00;
            phones_source_led_out <= 7'h00;
            dub_row1_led_out <= 1'b0;
            input7_hilvl_led_out <= 1'b0;
            dub_hilvl_led_out <= 1'b0;
            audio_mute_out <= 1'b0;
            input_hilvl_out <= 7'h00;
            input_mono_out <= 7'h00;
            dub_hilvl_out <= 1'b0;
            talk_studio_out <= 1'b0;
            talk_phones_out <= 1'b0;
            remote_src_sel_out <= 1'b0;
        end else begin
            configure_led_out <= in_cfg_w & flash_ff;
            audio_mute_out <= in_cfg_w;
            if (in_cfg_w) begin
                room_source_led_out <= pend_hilvl_ff;
                phones_source_led_out <= pend_mono_ff;
                dub_row1_led_out <= pend_dub_ff;
            end else begin
                // Normal role: mono inputs blink
                room_source_led_out <= 7'h00;
                phones_source_led_out <= app_mono_ff & {7{flash_ff}};
                dub_row1_led_out <= 1'b0;
            end
            input7_hilvl_led_out <= app_hilvl_ff[6];
            dub_hilvl_led_out <= app_dub_ff;
            input_hilvl_out <= app_hilvl_ff;
            input_mono_out <= app_mono_ff;
            dub_hilvl_out <= app_dub_ff;
            talk_studio_out <= ~in_cfg_w & (loc_s_w | rem_s_w);
            talk_phones_out <= ~in_cfg_w & (loc_p_w | rem_ring_w);
            remote_src_sel_out <= ~in_cfg_w & rem_src_w;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    reg wr_pend_ff;
    reg [7:0] addr_ff;
    wire take_w = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            ctrl_ff <= 3'h0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= take_w & hwrite;
            if (take_w) begin
                addr_ff <= haddr[7:0];
            end
            if (wr_pend_ff && addr_ff == `CCC_ADDR_CTRL) begin
                ctrl_ff <= hwdata[2:0];
            end
            if (take_w && !hwrite) begin
                case (haddr[7:0])
                    `CCC_ADDR_STATUS:
                        hrdata <= {25'h0000000, loc_p_w, loc_s_w, rem_ring_w, rem_src_w, rem_s_w,
                                   in_cfg_w, state_ff != ST_NORMAL && state_ff != ST_HOLD};
                    `CCC_ADDR_APPLIED:
                        hrdata <= {15'h0000, app_dub_ff, 1'b0, app_mono_ff, 1'b0, app_hilvl_ff};
                    `CCC_ADDR_PENDING:
                        hrdata <= {15'h0000, pend_dub_ff, 1'b0, pend_mono_ff, 1'b0, pend_hilvl_ff};
                    `CCC_ADDR_CTRL:
                        hrdata <= {29'h00000000, ctrl_ff};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// File: verilog/ccc_map.vh
// Register map, field positions, reset values and timing constants for the console configure controller
`ifndef CCC_MAP_VH
`define CCC_MAP_VH
`define CCC_CLK_HZ 10000000
`define CCC_CFG_HOLD_MS 2000
`define CCC_CFG_HOLD_CYC ((`CCC_CLK_HZ / 1000) * `CCC_CFG_HOLD_MS)
`define CCC_DEB_MS 10
`define CCC_DEB_CYC ((`CCC_CLK_HZ / 1000) * `CCC_DEB_MS)
`define CCC_FLASH_MS 250
`define CCC_FLASH_CYC ((`CCC_CLK_HZ / 1000) * `CCC_FLASH_MS)
`define CCC_NUM_IN 7
// Register byte addresses
`define CCC_ADDR_STATUS 8'h00
`define CCC_ADDR_APPLIED 8'h04
`define CCC_ADDR_PENDING 8'h08
`define CCC_ADDR_CTRL 8'h0C
// Field positions in APPLIED / PENDING
`define CCC_F_HILVL_LSB 0
`define CCC_F_MONO_LSB 8
`define CCC_F_DUBHI 16
// Field positions in STATUS
`define CCC_F_CFGMODE 0
`define CCC_F_MUTE 1
`define CCC_F_REM_TALK_STUDIO 2
`define CCC_F_REM_SRC_SEL 3
`define CCC_F_REM_TALK_PHONES 4
`define CCC_F_TALK_STUDIO 5
`define CCC_F_TALK_PHONES 6
// Field positions in CTRL
`define CCC_F_REM1_SRC 0
`define CCC_F_LATCH_STUDIO 1
`define CCC_F_LATCH_PHONES 2
`define CCC_RST_APPLIED 32'h0000_0000
`define CCC_RST_CTRL 32'h0000_0000
`endif

// File: verilog/ccc_debounce.v
// Two-flop synchroniser and stable-time debouncer, one per input bit
`timescale 1ns/1ns
`include "ccc_map.vh"
module ccc_debounce #(
    parameter WIDTH = 12,
    parameter DEB_CYC = `CCC_DEB_CYC
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [WIDTH-1:0] raw_in,
    output wire [WIDTH-1:0] clean_out,
    output wire [WIDTH-1:0] rise_out
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : bit_deb
            reg meta_ff;
            reg sync_ff;
            reg stable_ff;
            reg stable_d_ff;
            reg [19:0] cnt_ff;
            always @(posedge core_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                    stable_ff <= 1'b0;
                    stable_d_ff <= 1'b0;
                    cnt_ff <= 20'h00000;
                end else begin
                    meta_ff <= raw_in[g];
                    sync_ff <= meta_ff;
                    stable_d_ff <= stable_ff;
                    // A level must hold for the whole window before it is believed
                    if (sync_ff == stable_ff) begin
                        cnt_ff <= 20'h00000;
                    end else if (cnt_ff >= DEB_CYC - 1) begin
                        cnt_ff <= 20'h00000;
                        stable_ff <= sync_ff;
                    end else begin
                        cnt_ff <= cnt_ff + 20'h00001;
                    end
                end
            end
            assign clean_out[g] = stable_ff;
            assign rise_out[g] = stable_ff & ~stable_d_ff;
        end
    endgenerate
endmodule

// File: tb/ccc_properties.sv
// Port-level assertions for the console configure controller
`timescale 1ns/1ns
module ccc_properties #(
    parameter CFG_HOLD_CYC = 50,
    parameter DEB_CYC = 4,
    parameter FLASH_CYC = 8
) (
    input wire core_clk_in,
    input wire nrst_in,
    input wire configure_btn_in,
    input wire talk_studio_btn_in,
    input wire talk_phones_btn_in,
    input wire remote_tip_n_in,
    input wire remote_ring_n_in,
    input wire configure_led_out,
    input wire [6:0] room_source_led_out,
    input wire input7_hilvl_led_out,
    input wire dub_hilvl_led_out,
    input wire audio_mute_out,
    input wire [6:0] input_hilvl_out,
    input wire [6:0] input_mono_out,
    input wire dub_hilvl_out,
    input wire talk_studio_out,
    input wire talk_phones_out,
    input wire remote_src_sel_out
);
    localparam int FL_MAX = 2 * FLASH_CYC + 4;
    logic [31:0] hold_cnt_ff;
    wire ts_req = talk_studio_btn_in | ~remote_tip_n_in;
    wire tp_req = talk_phones_btn_in | ~remote_ring_n_in;
    // Raw pin time; the debounced path can only be slower than this
    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) hold_cnt_ff <= 32'h0;
        else hold_cnt_ff <= configure_btn_in ? hold_cnt_ff + 32'h1 : 32'h0;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_cfg;
        audio_mute_out && $past(audio_mute_out);
    endsequence
    sequence s_norm;
        !audio_mute_out && !$past(audio_mute_out);
    endsequence
    chk_entry_hold: assert property ($rose(audio_mute_out) |-> hold_cnt_ff >= CFG_HOLD_CYC)
        else $error("configure entered before full hold");
    chk_cfg_flash: assert property (s_cfg |-> ##[1:FL_MAX] ($changed(configure_led_out) || !audio_mute_out))
        else $error("configure indicator not flashing");
    chk_cfg_quiet: assert property (s_cfg |-> !(talk_studio_out || talk_phones_out || remote_src_sel_out))
        else $error("normal function active in configure");
    chk_room_norm: assert property (s_norm |-> room_source_led_out == 7'h00)
        else $error("room indicators lit in normal mode");
    chk_applied_hold: assert property (s_cfg |-> $stable({input_hilvl_out, input_mono_out, dub_hilvl_out}))
        else $error("setting applied inside configure");
    chk_in7_led: assert property ($stable(input_hilvl_out) |-> input7_hilvl_led_out == input_hilvl_out[6])
        else $error("input seven level indicator wrong");
    chk_dub_led: assert property ($stable(dub_hilvl_out) |-> dub_hilvl_led_out == dub_hilvl_out)
        else $error("dub level indicator wrong");
    chk_ts_debounce: assert property ($rose(talk_studio_out) |-> $past(ts_req, DEB_CYC))
        else $error("studio talk without settled cause");
    chk_tp_remote: assert property ($rose(talk_phones_out) |-> $past(tp_req, DEB_CYC))
        else $error("phones talk without settled cause");
    chk_src_remote: assert property ($rose(remote_src_sel_out) |-> !$past(remote_tip_n_in, DEB_CYC))
        else $error("source select without tip closure");
    chk_exit_press: assert property ($fell(audio_mute_out) |-> $past(configure_btn_in, DEB_CYC))
        else $error("configure left without press");
endmodule
bind ccc_top ccc_properties #(.CFG_HOLD_CYC(CFG_HOLD_CYC), .DEB_CYC(DEB_CYC), .FLASH_CYC(FLASH_CYC)) chk (
    .core_clk_in, .nrst_in, .configure_btn_in, .talk_studio_btn_in, .talk_phones_btn_in, .remote_tip_n_in,
    .remote_ring_n_in, .configure_led_out, .room_source_led_out, .input7_hilvl_led_out, .dub_hilvl_led_out,
    .audio_mute_out, .input_hilvl_out, .input_mono_out, .dub_hilvl_out, .talk_studio_out, .talk_phones_out,
    .remote_src_sel_out);

// File: tb/ccc_panel.sv
// Operator panel model: buttons and remote contacts, with contact bounce
`timescale 1ns/1ns
module ccc_panel (
    input wire core_clk_in,
    input wire [13:0] press_in,
    output logic [13:0] pin_out
);
    // Remote contacts idle high and go low when shorted to common
    localparam logic [13:0] LOW_ACT = 14'h0C00;
    logic [13:0] last_ff = 14'h0000;
    logic [13:0] chg_ff = 14'h0000;
    logic [1:0] bnc_ff = 2'h0;
    initial pin_out = LOW_ACT;
    // Changed contacts chatter for three cycles, shorter than the debounce window
    always @(posedge core_clk_in) begin
        last_ff <= press_in;
        if (press_in != last_ff) begin
            bnc_ff <= 2'h3;
            chg_ff <= press_in ^ last_ff;
        end else if (bnc_ff != 2'h0) begin
            bnc_ff <= bnc_ff - 2'h1;
        end
        pin_out <= (bnc_ff != 2'h0) ? pin_out ^ chg_ff : press_in ^ LOW_ACT;
    end
endmodule

// File: tb/ccc_top_tb.sv
// Self-checking bench for the console configure controller
`timescale 1ns/1ns
module ccc_top_tb;
    localparam logic [13:0] P_PH = 14'h0080, P_DUB = 14'h0100, P_CFG = 14'h0200;
    localparam logic [13:0] P_TIP = 14'h0400, P_RING = 14'h0800, P_TS = 14'h1000;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [13:0] press = 14'h0;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, cfg_led, row1, in7_led, dub_led, mute, dub_hi, ts, tp, src;
    wire [13:0] pin;
    wire [6:0] room_led, ph_led, hil, mono;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int k;
    ccc_panel panel (.core_clk_in(core_clk_in), .press_in(press), .pin_out(pin));
    ccc_top #(.CFG_HOLD_CYC(50), .DEB_CYC(4), .FLASH_CYC(8)) dut (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .configure_btn_in(pin[9]), .room_source_buttons_in(pin[6:0]),
        .phones_source_btn_in(pin[7]), .dub_btn_in(pin[8]), .talk_studio_btn_in(pin[12]),
        .talk_phones_btn_in(pin[13]), .remote_tip_n_in(pin[10]), .remote_ring_n_in(pin[11]),
        .configure_led_out(cfg_led), .room_source_led_out(room_led), .phones_source_led_out(ph_led),
        .dub_row1_led_out(row1), .input7_hilvl_led_out(in7_led), .dub_hilvl_led_out(dub_led),
        .audio_mute_out(mute), .input_hilvl_out(hil), .input_mono_out(mono), .dub_hilvl_out(dub_hi),
        .talk_studio_out(ts), .talk_phones_out(tp), .remote_src_sel_out(src));
    initial forever #50 core_clk_in = ~core_clk_in;
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Budget is several times the expected run, so only a hang trips it
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic hold(input logic [13:0] p, input int n);
        press <= p;
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic tap(input logic [13:0] p);
        hold(p, 20);
        hold(14'h0, 20);
    endtask
    task automatic flips(input logic mono_led, output int n);
        logic prev;
        logic v;
        n = 0;
        prev = mono_led ? ph_led[0] : cfg_led;
        repeat (40) begin
            @(posedge core_clk_in);
            v = mono_led ? ph_led[0] : cfg_led;
            if (v !== prev) n++;
            prev = v;
        end
    endtask
    initial begin
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(posedge core_clk_in);
        chk("leds", 32'h0, {cfg_led, room_led, ph_led, row1, in7_led, dub_led});
        chk("outputs", 32'h0, {mute, hil, mono, dub_hi, ts, tp, src});
        chk("bus response", 32'h0, {hresp, ~hreadyout});
        rdchk("ctrl", 32'h0C, 32'h0);
        rdchk("applied", 32'h04, 32'h0);
        bus(1'b1, 32'h10, 32'hFFFF_FFFF);
        rdchk("unmapped", 32'h10, 32'h0);
        $display("test reset done");
        hold(P_CFG, 30);
        hold(14'h0, 20);
        chk("short hold", 32'h0, mute);
        hold(P_CFG, 70);
        chk("entry mute", 32'h1, mute);
        hold(14'h0, 20);
        flips(1'b0, k);
        chk("cfg flash", 32'h1, k >= 2);
        hold(P_TIP, 20);
        chk("remote in cfg", 32'h0, {ts, src});
        hold(14'h0, 20);
        tap(14'h0040);
        chk("room leds", 32'h40, room_led);
        chk("level held", 32'h0, {hil, in7_led});
        hold(P_PH, 20);
        tap(P_PH | 14'h0001);
        chk("mono leds", 32'h01, ph_led);
        chk("room kept", 32'h40, room_led);
        tap(P_DUB);
        chk("row1", 32'h1, row1);
        chk("dub held", 32'h0, {dub_led, dub_hi});
        rdchk("pending", 32'h08, 32'h0001_0140);
        rdchk("status cfg", 32'h00, 32'h3);
        $display("test configure done");
        tap(P_CFG);
        chk("exit mute", 32'h0, mute);
        chk("applied outs", {7'h40, 7'h01, 1'b1}, {hil, mono, dub_hi});
        chk("front leds", 32'h3, {in7_led, dub_led});
        chk("room normal", 32'h0, room_led);
        rdchk("applied", 32'h04, 32'h0001_0140);
        flips(1'b1, k);
        chk("mono flash", 32'h1, k >= 2);
        $display("test exit done");
        hold(P_TIP, 20);
        chk("tip talk", 32'h2, {ts, src});
        hold(14'h0, 20);
        chk("tip open", 32'h0, ts);
        hold(P_RING, 20);
        chk("ring talk", 32'h1, tp);
        rdchk("status ring", 32'h00, 32'h10);
        hold(14'h0, 20);
        bus(1'b1, 32'h0C, 32'h7);
        rdchk("ctrl", 32'h0C, 32'h7);
        hold(P_TIP, 20);
        chk("tip source", 32'h1, {ts, src});
        hold(14'h0, 20);
        chk("src open", 32'h0, src);
        tap(P_RING);
        chk("ring momentary", 32'h0, tp);
        tap(P_TS);
        chk("local latch", 32'h1, ts);
        tap(P_TS);
        chk("local unlatch", 32'h0, ts);
        bus(1'b1, 32'h0C, 32'h0);
        hold(P_RING, 20);
        hold(P_RING | P_TS, 20);
        chk("local with remote", 32'h3, {ts, tp});
        hold(14'h0, 20);
        $display("test remote done");
        complete_run();
    end
endmodule
